// ### rtl/rbs_pkg.sv
// Purpose: constants and types for the reset, boot and shutdown sequencer
// Assumes: 50 MHz system clock, slow oscillator tick generated by a divider
// Notes:   all timing figures kept in their printed units
package rbs_pkg;
  localparam int unsigned CLOCK_HZ        = 50_000_000;
  localparam int unsigned SLOW_OSC_HZ     = 20_000;
  localparam int unsigned FAST_OSC_HZ     = 12_000_000;
  localparam int unsigned RESET_DELAY_MS  = 50;
  localparam int unsigned SLOW_DIV_CYCLES = CLOCK_HZ / SLOW_OSC_HZ;
  localparam int unsigned DELAY_TICKS     = (RESET_DELAY_MS * SLOW_OSC_HZ) / 1000;
  localparam int unsigned DIV_W           = 12;
  localparam int unsigned TICK_W          = 11;
  localparam int unsigned PIN_COUNT       = 32;
  localparam int unsigned EEPROM_CLK_IDX  = 28;
  localparam int unsigned EEPROM_DAT_IDX  = 29;
  localparam int unsigned HOST_TX_IDX     = 30;
  localparam int unsigned HOST_RX_IDX     = 31;
  localparam logic [PIN_COUNT-1:0] BOOT_PIN_MASK = 32'hf000_0000;

  typedef enum logic [2:0] {
    RBS_SHUTDOWN,
    RBS_DELAY,
    RBS_HOST_CHECK,
    RBS_EEPROM_LOAD,
    RBS_RUN
  } rbs_state_type;

  // boot loader handshake from the processor 0 firmware
  typedef struct packed {
    logic host_seen;
    logic host_done;
    logic host_loaded;
    logic host_suspend;
    logic eeprom_done;
    logic eeprom_found;
  } rbs_boot_type;

  // per-processor and pin control toward the core
  typedef struct packed {
    logic [7:0]           cog_enable;
    logic                 run_loader;
    logic                 run_interp;
    logic                 boot_pins;
    logic                 fast_osc;
    logic                 clock_run;
  } rbs_ctrl_type;
endpackage : rbs_pkg

// ### rtl/rbs_sequencer.sv
// Purpose: chip reset, boot order and shutdown sequencing
// Assumes: pin inputs synchronous to clock; loader firmware reports on boot_status
// Notes:   pin drive is gated here; the core supplies its normal pin outputs
module rbs_sequencer
  import rbs_pkg::*;
#(
  // defaults give the full 50 ms; smaller values only shorten simulation
  parameter int unsigned DELAY_COUNT = DELAY_TICKS,
  parameter int unsigned SLOW_DIVIDE = SLOW_DIV_CYCLES
)
(
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire logic                 chip_reset_low_in,
  output logic                      chip_reset_low_out,
  output logic                      chip_reset_low_oe,
  input  wire logic                 brownout_detect_enable_low,
  input  wire logic                 supply_below_threshold,
  input  wire logic                 reboot_request,
  input  wire rbs_boot_type         boot_status,
  input  wire logic [PIN_COUNT-1:0] core_pin_out,
  input  wire logic [PIN_COUNT-1:0] core_pin_oe,
  input  wire logic                 eeprom_clock_pin_out,
  input  wire logic                 eeprom_clock_pin_oe,
  input  wire logic                 eeprom_data_pin_out,
  input  wire logic                 eeprom_data_pin_oe,
  input  wire logic                 host_transmit_pin_out,
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0]      pin_out,
  output logic [PIN_COUNT-1:0]      pin_oe,
  output logic                      host_receive_pin,
  output logic                      eeprom_data_pin_in,
  output rbs_ctrl_type              ctrl
);

  rbs_state_type         state_q, state_d;
  logic [DIV_W-1:0]      div_q;
  logic [TICK_W-1:0]     ticks_q;
  logic                  shutdown_cause;
  logic                  slow_tick;
  logic                  delay_done;
  logic                  boot_phase;
  logic [PIN_COUNT-1:0]  boot_out;
  logic [PIN_COUNT-1:0]  boot_oe;
  logic                  brownout_on;

  // weak high monitor drive; external low still wins on the wire
  assign brownout_on        = !brownout_detect_enable_low;
  assign chip_reset_low_out = 1'b1;
  assign chip_reset_low_oe  = brownout_on;

  assign shutdown_cause = (brownout_on && supply_below_threshold)
                        || !chip_reset_low_in || reboot_request;

  assign slow_tick  = (div_q == DIV_W'(SLOW_DIVIDE - 1));
  assign delay_done = slow_tick && (ticks_q == TICK_W'(DELAY_COUNT - 1));

  always_ff @(posedge clock) begin
    if (reset || state_q != RBS_DELAY || slow_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // counting runs on the slow oscillator rate; any fault starts it over
  always_ff @(posedge clock) begin
    if (reset || state_q != RBS_DELAY || shutdown_cause) begin
      ticks_q <= '0;
    end else if (slow_tick) begin
      ticks_q <= ticks_q + TICK_W'(1);
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      RBS_SHUTDOWN:    if (!shutdown_cause) state_d = RBS_DELAY;
      RBS_DELAY:       if (shutdown_cause) state_d = RBS_SHUTDOWN;
                       else if (delay_done) state_d = RBS_HOST_CHECK;
      RBS_HOST_CHECK:  if (shutdown_cause) state_d = RBS_SHUTDOWN;
                       else if (boot_status.host_seen) begin
                         if (boot_status.host_done) begin
                           state_d = (boot_status.host_loaded && !boot_status.host_suspend)
                                   ? RBS_RUN : RBS_SHUTDOWN;
                         end
                       end else if (boot_status.host_done) state_d = RBS_EEPROM_LOAD;
      RBS_EEPROM_LOAD: if (shutdown_cause) state_d = RBS_SHUTDOWN;
                       else if (boot_status.eeprom_done) begin
                         state_d = boot_status.eeprom_found ? RBS_RUN : RBS_SHUTDOWN;
                       end
      RBS_RUN:         if (shutdown_cause) state_d = RBS_SHUTDOWN;
      default:         state_d = RBS_SHUTDOWN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= RBS_SHUTDOWN;
    end else begin
      state_q <= state_d;
    end
  end

  assign boot_phase      = (state_q == RBS_HOST_CHECK) || (state_q == RBS_EEPROM_LOAD);
  assign ctrl.clock_run  = (state_q != RBS_SHUTDOWN);
  assign ctrl.fast_osc   = boot_phase || (state_q == RBS_RUN);
  assign ctrl.cog_enable = boot_phase ? 8'h01 : (state_q == RBS_RUN ? 8'hff : 8'h00);
  assign ctrl.run_loader = boot_phase;
  assign ctrl.run_interp = (state_q == RBS_RUN);
  assign ctrl.boot_pins  = boot_phase;

  // boot loader owns pins 28 to 31 only while booting
  always_comb begin
    boot_out = '0;
    boot_oe  = '0;
    boot_out[EEPROM_CLK_IDX] = eeprom_clock_pin_out;
    boot_oe[EEPROM_CLK_IDX]  = eeprom_clock_pin_oe;
    boot_out[EEPROM_DAT_IDX] = eeprom_data_pin_out;
    boot_oe[EEPROM_DAT_IDX]  = eeprom_data_pin_oe;
    boot_out[HOST_TX_IDX]    = host_transmit_pin_out;
    boot_oe[HOST_TX_IDX]     = 1'b1;
  end

  // pins float outside boot and run, including shutdown and the delay
  assign pin_out = boot_phase ? boot_out
                 : (state_q == RBS_RUN ? core_pin_out : '0);
  assign pin_oe  = boot_phase ? boot_oe
                 : (state_q == RBS_RUN ? core_pin_oe : '0);
  assign host_receive_pin   = pin_in[HOST_RX_IDX];
  assign eeprom_data_pin_in = pin_in[EEPROM_DAT_IDX];

  a_reset_floats: assert property (@(posedge clock) disable iff (reset)
    !chip_reset_low_in |=> (pin_oe == '0) && (ctrl.cog_enable == 8'h00))
    else $error("pins or processors active after reset low");
  a_strap_drive: assert property (@(posedge clock) disable iff (reset)
    chip_reset_low_oe == !brownout_detect_enable_low)
    else $error("reset pin drive does not follow strap");
  a_boot_one_cog: assert property (@(posedge clock) disable iff (reset)
    boot_phase |-> ctrl.cog_enable == 8'h01 && ctrl.fast_osc)
    else $error("boot not on processor 0 alone");
  sequence s_delay_end;
    state_q == RBS_DELAY && delay_done && !shutdown_cause;
  endsequence
  a_delay_to_boot: assert property (@(posedge clock) disable iff (reset)
    s_delay_end |=> state_q == RBS_HOST_CHECK)
    else $error("no boot after delay");
  a_slow_in_delay: assert property (@(posedge clock) disable iff (reset)
    state_q == RBS_DELAY |-> !ctrl.fast_osc)
    else $error("fast oscillator during delay");
  a_fault_restart: assert property (@(posedge clock) disable iff (reset)
    state_q == RBS_DELAY && shutdown_cause |=> ticks_q == '0)
    else $error("delay count not restarted");
  a_tick_rate: assert property (@(posedge clock) disable iff (reset)
    state_q == RBS_DELAY && !slow_tick && !shutdown_cause |=> $stable(ticks_q))
    else $error("delay count moved between slow ticks");
  a_none_shutdown: assert property (@(posedge clock) disable iff (reset)
    state_q == RBS_EEPROM_LOAD && !shutdown_cause && boot_status.eeprom_done
    && !boot_status.eeprom_found |=> state_q == RBS_SHUTDOWN && pin_oe == '0)
    else $error("no shutdown without boot source");
  a_enter_shut: assert property (@(posedge clock) disable iff (reset)
    state_q != RBS_SHUTDOWN && shutdown_cause |=> !ctrl.clock_run)
    else $error("shutdown cause ignored");
  a_leave_shut: assert property (@(posedge clock) disable iff (reset)
    state_q == RBS_SHUTDOWN && shutdown_cause |=> state_q == RBS_SHUTDOWN)
    else $error("left shutdown too early");
  a_shut_quiet: assert property (@(posedge clock) disable iff (reset)
    state_q == RBS_SHUTDOWN |-> !ctrl.clock_run && pin_oe == '0 && ctrl.cog_enable == 8'h00)
    else $error("shutdown left clock or pins active");
  a_run_interp: assert property (@(posedge clock) disable iff (reset)
    state_q == RBS_RUN |-> ctrl.run_interp && !ctrl.boot_pins)
    else $error("interpreter not running");
  a_run_pins_free: assert property (@(posedge clock) disable iff (reset)
    state_q == RBS_RUN |-> pin_oe == core_pin_oe && pin_out == core_pin_out)
    else $error("boot pins not released after boot");
  a_host_first: assert property (@(posedge clock) disable iff (reset)
    $rose(boot_phase) |-> state_q == RBS_HOST_CHECK)
    else $error("boot did not start with host check");

  // the loader firmware gives the verdict; this block only follows it
  sequence s_host_end;
    state_q == RBS_HOST_CHECK && !shutdown_cause && boot_status.host_seen
    && boot_status.host_done;
  endsequence
  sequence s_host_miss;
    state_q == RBS_HOST_CHECK && !shutdown_cause && !boot_status.host_seen
    && boot_status.host_done;
  endsequence
  sequence s_eeprom_end;
    state_q == RBS_EEPROM_LOAD && !shutdown_cause && boot_status.eeprom_done;
  endsequence
  a_host_to_run: assert property (@(posedge clock) disable iff (reset)
    s_host_end ##0 (boot_status.host_loaded && !boot_status.host_suspend)
    |=> state_q == RBS_RUN)
    else $error("host load did not start the interpreter");
  a_host_suspend: assert property (@(posedge clock) disable iff (reset)
    s_host_end ##0 boot_status.host_suspend
    |=> state_q == RBS_SHUTDOWN)
    else $error("suspended host load still ran");
  a_host_miss: assert property (@(posedge clock) disable iff (reset)
    s_host_miss |=> state_q == RBS_EEPROM_LOAD)
    else $error("no eeprom probe after silent host");
  a_eeprom_run: assert property (@(posedge clock) disable iff (reset)
    s_eeprom_end ##0 boot_status.eeprom_found |=> state_q == RBS_RUN && ctrl.run_interp)
    else $error("eeprom image loaded but not run");

endmodule : rbs_sequencer

// ### bench/rbs_loader_model.sv
// Purpose: loader firmware, host link and eeprom stand-in
// Assumes: mode 0 nothing present, 1 host download, 2 eeprom image, 3 host suspends
// Notes:   answers a few cycles after the loader starts, never wrongly
module rbs_loader_model
  import rbs_pkg::*;
(
  input  wire logic         clock,
  input  wire rbs_ctrl_type ctrl,
  input  wire logic [1:0]   mode,
  output rbs_boot_type      boot_status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  always_ff @(posedge clock) begin
    if (!ctrl.run_loader) wait_q <= 4'h0;
    else if (wait_q != 4'hf) wait_q <= wait_q + 4'h1;
  end
  // host is asked first, eeprom only later
  assign boot_status.host_seen    = (wait_q > 4'h3) && mode[0];
  assign boot_status.host_done    = wait_q > 4'h3;
  assign boot_status.host_loaded  = mode[0];
  assign boot_status.host_suspend = mode == 2'h3;
  assign boot_status.eeprom_done  = wait_q > 4'h7;
  assign boot_status.eeprom_found = mode == 2'h2;
endmodule : rbs_loader_model

// ### bench/reset_boot_shutdown_sequencer_test.sv
// Purpose: self-checking bench for the reset, boot and shutdown sequencer
// Assumes: delay divider and tick count shortened through the dut parameters
// Notes:   the full 50 ms figure is held against the package constants only
module reset_boot_shutdown_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rbs_pkg::*;
  localparam int unsigned T_DIV        = 25;
  localparam int unsigned T_TICKS      = 40;
  localparam int unsigned DELAY_CYCLES = T_DIV * T_TICKS;
  logic clock = 0, reset = 1, chip_reset_low_in = 0, brownout_detect_enable_low = 1;
  logic supply_below_threshold = 0, reboot_request = 0, chip_reset_low_out, chip_reset_low_oe;
  logic host_receive_pin, eeprom_data_pin_in;
  logic [1:0]  mode = 0;
  logic [4:0]  ldr = 5'h1b;
  logic [31:0] pin_in = 32'ha5a5_5a5a, core_out = 32'h1234_5678, core_oe = 32'h0f0f_f0f0;
  logic [31:0] pin_out, pin_oe;
  rbs_boot_type boot_status;
  rbs_ctrl_type ctrl;
  int mismatches = 0, checks_done = 0, n;
  always #10 clock = ~clock;
  rbs_loader_model model (.clock(clock), .ctrl(ctrl), .mode(mode), .boot_status(boot_status));
  rbs_sequencer #(.DELAY_COUNT(T_TICKS), .SLOW_DIVIDE(T_DIV)) dut (.clock(clock),
    .reset(reset), .chip_reset_low_in(chip_reset_low_in),
    .chip_reset_low_out(chip_reset_low_out), .chip_reset_low_oe(chip_reset_low_oe),
    .brownout_detect_enable_low(brownout_detect_enable_low), .reboot_request(reboot_request),
    .supply_below_threshold(supply_below_threshold), .boot_status(boot_status),
    .core_pin_out(core_out), .core_pin_oe(core_oe), .eeprom_clock_pin_out(ldr[4]),
    .eeprom_clock_pin_oe(ldr[3]), .eeprom_data_pin_out(ldr[2]), .eeprom_data_pin_oe(ldr[1]),
    .host_transmit_pin_out(ldr[0]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .host_receive_pin(host_receive_pin), .eeprom_data_pin_in(eeprom_data_pin_in), .ctrl(ctrl));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick
  task t_pin;
    check("delay constant", DELAY_TICKS * SLOW_DIV_CYCLES, 2_500_000);
    @(posedge clock) brownout_detect_enable_low <= 1'b0;
    tick(1);
    check("reset pin oe", chip_reset_low_oe, 1);
    check("reset pin out", chip_reset_low_out, 1);
    @(posedge clock) brownout_detect_enable_low <= 1'b1;
    tick(8);
    check("reset pin oe", chip_reset_low_oe, 0);
    check("pins float", pin_oe, 0);
    check("cogs off", ctrl.cog_enable, 0);
    check("rx pin", host_receive_pin, pin_in[31]);
    check("sda pin", eeprom_data_pin_in, pin_in[29]);
    @(posedge clock) begin
      chip_reset_low_in <= 1'b1;
      supply_below_threshold <= 1'b1;
    end
    tick(3);
    check("strap high ignores supply", ctrl.clock_run, 1);
    @(posedge clock) brownout_detect_enable_low <= 1'b0;
    tick(20);
    check("low supply holds", ctrl.clock_run, 0);
    $display("pin test done");
  endtask : t_pin
  task automatic t_boot(input logic [1:0] m);
    @(posedge clock) begin
      mode <= m;
      chip_reset_low_in <= 1'b1;
      supply_below_threshold <= 1'b0;
    end
    tick(DELAY_CYCLES / 2);
    check("slow osc", {ctrl.clock_run, ctrl.fast_osc}, 2'b10);
    @(posedge clock) supply_below_threshold <= 1'b1;
    @(posedge clock) supply_below_threshold <= 1'b0;
    #1;
    check("brownout abort", ctrl.clock_run, 0);
    n = 0;
    while (ctrl.cog_enable !== 8'h01 && n < DELAY_CYCLES + 100) begin
      tick(1);
      n++;
    end
    check("delay length", n, DELAY_CYCLES + 1);
    check("loader only", {ctrl.cog_enable, ctrl.run_loader, ctrl.fast_osc}, 10'h007);
    check("boot pins", {pin_oe[31:28], pin_out[30:28]},
      {2'b01, ldr[1], ldr[3], ldr[0], ldr[2], ldr[4]});
    n = 0;
    while (ctrl.cog_enable === 8'h01 && n < 100) begin
      tick(1);
      n++;
    end
    if (m == 2'h1 || m == 2'h2) begin
      check("run cogs", {ctrl.cog_enable, ctrl.run_interp}, 9'h1ff);
      check("user oe", pin_oe, core_oe);
      check("user out", pin_out, core_out);
    end else begin
      check("shutdown", ctrl, 0);
      check("pins input", pin_oe, 0);
    end
    $display("boot test %0d done", m);
  endtask : t_boot
  task t_stop(input logic by_reboot);
    @(posedge clock) begin
      reboot_request <= by_reboot;
      chip_reset_low_in <= by_reboot;
    end
    @(posedge clock) reboot_request <= 1'b0;
    #1;
    check("stop clock", {ctrl.clock_run, ctrl.cog_enable}, 0);
    check("stop pins", pin_oe, 0);
    $display("stop test done");
  endtask : t_stop
  initial begin
    #300_000;
    mismatches++;
    results();
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    t_pin();
    t_boot(2'h1);
    t_stop(1'b1);
    t_boot(2'h2);
    t_stop(1'b0);
    t_boot(2'h0);
    t_boot(2'h3);
    results();
  end
endmodule : reset_boot_shutdown_sequencer_test
